// ==== ddrpw_pkg.sv ====
// Shared constants and types for the DRAM CKE power-state link.
// Function
// RULE1 - Decide transitions from previous and current CKE
// RULE2 - Power-down entry and exit only with NOP
// RULE3 - Self-refresh exit only with NOP or deselect
// RULE4 - Idle banks give precharge, open rows active
// RULE5 - Self refresh entered only with banks idle
// RULE6 - No power-down while operations still running
// RULE7 - Hold each CKE level three registered edges
// RULE8 - No refresh performed while in power-down
// RULE9 - Only NOP until tXSNR after self-refresh exit
// RULE10 - No READ for 200 clocks after exit
// RULE11 - ODT ignored; termination off in self refresh
// RULE12 - Drive ODT valid throughout power-down
// RULE13 - Undefined combinations are illegal, never produced
// RULE14 - Drop CKE only after read burst completes
// RULE15 - Write auto-precharge: power-down after write recovery
// RULE16 - Power-down one clock after REF, ACT, PRE
// RULE17 - Mode load needs idle banks, wait tMRD
// RULE18 - Frequency change: precharge power-down, ODT low, wait
// RULE19 - Stable new clock one cycle before exit
// RULE20 - Reset DLL through mode load after exit
// RULE21 - ODT off during 200-cycle DLL relock
// RULE22 - REFRESH with CKE falling enters self refresh
// RULE23 - Mode bit 12 selects fast or slow exit
// RULE24 - Track open rows to classify power-down
package ddrpw_pkg;

  // ****************************************************************
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ****************************************************************
  localparam logic [3:0] CMD_MRL = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  localparam int AUTO_PRE_BIT   = 10;
  localparam int MR_FAST_EXIT_BIT = 12;
  localparam logic [12:0] MR_DLL_RESET_VAL = 13'h0100;

  // ****************************************************************
  // Controller register map and fields
  // ****************************************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD  = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;

  localparam int CTRL_PD_BIT   = 0;
  localparam int CTRL_SR_BIT   = 1;
  localparam int CTRL_FREQ_BIT = 2;
  localparam int CTRL_ODT_BIT  = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BA_LSB   = 4;
  localparam int CMD_ADDR_LSB = 8;

  localparam int STAT_BANK_LSB = 8;
  localparam int STAT_ERR_BIT  = 16;
  localparam int STAT_CLK_BIT  = 17;
  localparam int STAT_BUSY_BIT = 18;
  localparam int STAT_CKE_BIT  = 19;

  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_RD  = 3'h2;
  localparam logic [2:0] OP_WR  = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  localparam logic [2:0] OP_REF = 3'h5;
  localparam logic [2:0] OP_MRL = 3'h6;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS    = 10;
  localparam int T_XSNR_NS = 198;
  localparam logic [7:0] XSNR_CYC =
    8'((T_XSNR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] CKE_MIN_CYC     = 2'h3;
  localparam logic [7:0] XSRD_CYC        = 8'hC8;
  localparam logic [7:0] RELOCK_CYC      = 8'hC8;
  localparam logic [7:0] FREQ_WAIT_CYC   = 8'h02;
  localparam logic [7:0] FREQ_STABLE_CYC = 8'h01;
  localparam logic [7:0] XP_CYC          = 8'h02;
  localparam logic [7:0] MRD_CYC         = 8'h02;
  localparam logic [7:0] AFTER_CMD_CYC   = 8'h01;
  localparam logic [7:0] RD_DONE_CYC     = 8'h08;
  localparam logic [7:0] WR_DONE_CYC     = 8'h0C;

  typedef enum logic [1:0] {
    DEV_ACTIVE = 2'b00,
    DEV_PD_PRE = 2'b01,
    DEV_PD_ACT = 2'b10,
    DEV_SR     = 2'b11
  } ddrpw_dev_state_t;

  typedef enum logic [2:0] {
    CTL_IDLE   = 3'b000,
    CTL_PD     = 3'b001,
    CTL_SR     = 3'b010,
    CTL_FREQ   = 3'b011,
    CTL_FSTAB  = 3'b100,
    CTL_DLLRST = 3'b101,
    CTL_RELOCK = 3'b110
  } ddrpw_ctl_state_t;

endpackage

// ==== ddrpw_if.sv ====
// Link between the memory controller and the DRAM power-state logic.
`timescale 1ns/1ns
interface ddrpw_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [12:0] addr;
  logic        odt;

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
  modport dev (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

// ==== ddrpw_device.sv ====
// DRAM-side CKE power-state tracker.
`timescale 1ns/1ns
module ddrpw_device (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  ddrpw_if.dev                             link,
  output ddrpw_pkg::ddrpw_dev_state_t      dev_state,
  output logic [7:0]                       banks_open,
  output logic                             fast_exit,
  output logic                             term_on,
  output logic                             self_refreshing,
  output logic                             illegal
);
  import ddrpw_pkg::*;

  typedef struct packed {
    ddrpw_dev_state_t st;
    logic             cke_prev;
    logic [7:0]       banks;
    logic             fast;
    logic             term;
    logic             illegal;
  } ddrpw_dev_s_t;

  ddrpw_dev_s_t s_r;
  ddrpw_dev_s_t s_nxt;
  logic [3:0]   cmd;
  logic         nopish;

  assign cmd    = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  assign nopish = link.cs_n || (cmd == CMD_NOP);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.cke_prev = link.cke; // RULE1
    s_nxt.illegal  = 1'b0;
    case (s_r.st)
      DEV_ACTIVE: begin
        if (s_r.cke_prev && !link.cke) begin // RULE1
          if (nopish) begin // RULE2
            s_nxt.st = (s_r.banks != 8'h00) ? DEV_PD_ACT : DEV_PD_PRE; // RULE4 RULE24
          end else if (cmd == CMD_REF && s_r.banks == 8'h00) begin
            s_nxt.st = DEV_SR; // RULE22
          end else begin
            s_nxt.illegal = 1'b1; // RULE13
          end
        end else if (s_r.cke_prev && link.cke && !nopish) begin
          case (cmd)
            CMD_ACT: s_nxt.banks[link.ba] = 1'b1; // RULE24
            CMD_PRE: begin
              if (link.addr[AUTO_PRE_BIT]) begin
                s_nxt.banks = 8'h00;
              end else begin
                s_nxt.banks[link.ba] = 1'b0;
              end
            end
            CMD_RD, CMD_WR: begin
              if (link.addr[AUTO_PRE_BIT]) begin
                s_nxt.banks[link.ba] = 1'b0;
              end
            end
            CMD_MRL: begin
              if (link.ba == 3'h0) begin
                s_nxt.fast = !link.addr[MR_FAST_EXIT_BIT]; // RULE23
              end
            end
            CMD_REF: begin
              if (s_r.banks != 8'h00) begin
                s_nxt.illegal = 1'b1; // RULE13
              end
            end
            default: s_nxt.illegal = 1'b1; // RULE13
          endcase
        end
      end
      // Power-down and self refresh both leave on CKE high; any command but NOP or deselect on that exit cycle is flagged.
      default: begin
        if (link.cke) begin
          s_nxt.st = DEV_ACTIVE;
          if (!nopish) begin
            s_nxt.illegal = 1'b1; // RULE2 RULE3
          end
        end
      end
    endcase
    // Termination follows ODT except in self refresh; state ignores it.
    s_nxt.term = link.odt && (s_nxt.st != DEV_SR); // RULE11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{st: DEV_ACTIVE, cke_prev: 1'b1, banks: 8'h00,
               fast: 1'b1, term: 1'b0, illegal: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dev_state       = s_r.st;
  assign banks_open      = s_r.banks;
  assign fast_exit       = s_r.fast;
  assign term_on         = s_r.term;
  // Internal refresh runs only in self refresh, never in power-down.
  assign self_refreshing = (s_r.st == DEV_SR); // RULE8
  assign illegal         = s_r.illegal;
endmodule

// ==== ddrpw_ctl.sv ====
// Memory-controller side: APB registers drive CKE power sequencing.
`timescale 1ns/1ns
module ddrpw_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  ddrpw_if.ctl             link
);
  import ddrpw_pkg::*;

  typedef struct packed {
    ddrpw_ctl_state_t st;
    logic             cke;
    logic             odt;
    logic [3:0]       cmd;
    logic [2:0]       ba;
    logic [12:0]      addr;
    logic [7:0]       banks;
    logic [7:0]       guard;
    logic [1:0]       hold;
    logic [7:0]       wait_c;
    logic [7:0]       rd_blk;
    logic [3:0]       ctrl;
    logic             pend;
    logic [2:0]       op;
    logic [2:0]       pba;
    logic [12:0]      paddr;
    logic             err;
    logic             clk_ok;
    logic [31:0]      rdata;
  } ddrpw_ctl_s_t;

  ddrpw_ctl_s_t s_r;
  ddrpw_ctl_s_t s_nxt;
  logic         wr;
  logic         mapped;
  logic         cke_can;
  logic         quiet;

  assign wr      = psel && penable && pwrite;
  assign mapped  = (paddr == REG_CTRL) || (paddr == REG_CMD) ||
                   (paddr == REG_STAT);
  // A CKE level may change only after three registered edges.
  assign cke_can = (s_r.hold == CKE_MIN_CYC); // RULE7
  // Power-state entry waits until the last issued operation has finished.
  assign quiet   = !s_r.pend && s_r.guard == 8'h00 &&
                   s_r.wait_c == 8'h00 && cke_can; // RULE6 RULE14

  always_comb begin
    s_nxt     = s_r;
    s_nxt.cmd = CMD_NOP;
    if (s_r.hold != CKE_MIN_CYC) begin
      s_nxt.hold = s_r.hold + 2'h1;
    end
    if (s_r.guard != 8'h00) begin
      s_nxt.guard = s_r.guard - 8'h01;
    end
    if (s_r.wait_c != 8'h00) begin
      s_nxt.wait_c = s_r.wait_c - 8'h01;
    end
    if (s_r.rd_blk != 8'h00) begin
      s_nxt.rd_blk = s_r.rd_blk - 8'h01;
    end

    // ****************************************************************
    // APB register access
    // ****************************************************************
    if (psel && !penable) begin
      case (paddr)
        REG_CTRL: s_nxt.rdata = {28'h0000000, s_r.ctrl};
        REG_CMD:  s_nxt.rdata = {11'h000, s_r.paddr, 1'b0, s_r.pba,
                                 s_r.pend, s_r.op};
        REG_STAT: s_nxt.rdata = {12'h000, s_r.cke, s_r.pend, s_r.clk_ok,
                                 s_r.err, s_r.banks, 5'h00, s_r.st};
        default:  s_nxt.rdata = 32'h00000000;
      endcase
    end
    // Clearing comes first so that an error in the same cycle wins.
    if (wr && paddr == REG_STAT && pwdata[STAT_ERR_BIT]) begin
      s_nxt.err = 1'b0;
    end
    if (wr && paddr == REG_CTRL) begin
      s_nxt.ctrl = pwdata[3:0];
    end
    if (wr && paddr == REG_CMD) begin
      if (s_r.pend) begin
        s_nxt.err = 1'b1;
      end else begin
        s_nxt.pend  = 1'b1;
        s_nxt.op    = pwdata[CMD_OP_LSB +: 3];
        s_nxt.pba   = pwdata[CMD_BA_LSB +: 3];
        s_nxt.paddr = pwdata[CMD_ADDR_LSB +: 13];
      end
    end

    // ****************************************************************
    // Power sequencing
    // ****************************************************************
    case (s_r.st)
      CTL_IDLE: begin
        s_nxt.odt = s_r.ctrl[CTRL_ODT_BIT];
        if (s_r.pend && s_r.wait_c == 8'h00 &&
            !(s_r.op == OP_RD && s_r.rd_blk != 8'h00)) begin // RULE9 RULE10
          s_nxt.pend  = 1'b0;
          s_nxt.ba    = s_r.pba;
          s_nxt.addr  = s_r.paddr;
          s_nxt.guard = AFTER_CMD_CYC; // RULE16
          case (s_r.op)
            OP_ACT: begin
              s_nxt.cmd             = CMD_ACT;
              s_nxt.banks[s_r.pba]  = 1'b1;
            end
            OP_RD, OP_WR: begin
              s_nxt.cmd   = (s_r.op == OP_RD) ? CMD_RD : CMD_WR;
              s_nxt.guard = (s_r.op == OP_RD) ? RD_DONE_CYC
                                              : WR_DONE_CYC; // RULE14 RULE15
              if (s_r.paddr[AUTO_PRE_BIT]) begin
                s_nxt.banks[s_r.pba] = 1'b0;
              end
            end
            OP_PRE: begin
              s_nxt.cmd = CMD_PRE;
              if (s_r.paddr[AUTO_PRE_BIT]) begin
                s_nxt.banks = 8'h00;
              end else begin
                s_nxt.banks[s_r.pba] = 1'b0;
              end
            end
            OP_REF, OP_MRL: begin
              // Refresh and mode loads are refused with rows open.
              if (s_r.banks != 8'h00) begin
                s_nxt.err = 1'b1; // RULE13 RULE17
              end else begin
                s_nxt.cmd   = (s_r.op == OP_REF) ? CMD_REF : CMD_MRL;
                s_nxt.guard = (s_r.op == OP_MRL) ? MRD_CYC
                                                : AFTER_CMD_CYC; // RULE17
              end
            end
            default: s_nxt.cmd = CMD_NOP;
          endcase
        end else if (quiet && s_r.ctrl[CTRL_SR_BIT]) begin
          if (s_r.banks != 8'h00) begin
            s_nxt.err = 1'b1; // RULE5
          end else begin
            s_nxt.cke  = 1'b0;
            s_nxt.cmd  = CMD_REF; // RULE22
            s_nxt.hold = 2'h0;
            s_nxt.odt  = 1'b0;
            s_nxt.st   = CTL_SR;
          end
        end else if (quiet && s_r.ctrl[CTRL_FREQ_BIT]) begin
          if (s_r.banks != 8'h00) begin
            s_nxt.err = 1'b1; // RULE18
          end else begin
            s_nxt.cke    = 1'b0;
            s_nxt.hold   = 2'h0;
            s_nxt.odt    = 1'b0;
            s_nxt.wait_c = FREQ_WAIT_CYC; // RULE18
            s_nxt.st     = CTL_FREQ;
          end
        end else if (quiet && s_r.ctrl[CTRL_PD_BIT]) begin
          s_nxt.cke  = 1'b0; // RULE2
          s_nxt.hold = 2'h0;
          s_nxt.st   = CTL_PD;
        end
      end
      CTL_PD: begin
        // ODT stays a driven level through power-down.
        s_nxt.odt = s_r.ctrl[CTRL_ODT_BIT]; // RULE12
        if (!s_r.ctrl[CTRL_PD_BIT] && cke_can) begin
          s_nxt.cke  = 1'b1; // RULE2
          s_nxt.hold = 2'h0;
          s_nxt.st   = CTL_IDLE;
        end
      end
      CTL_SR: begin
        s_nxt.odt = 1'b0;
        if (!s_r.ctrl[CTRL_SR_BIT] && cke_can) begin
          s_nxt.cke    = 1'b1; // RULE3
          s_nxt.hold   = 2'h0;
          s_nxt.wait_c = XSNR_CYC; // RULE9
          s_nxt.rd_blk = XSRD_CYC; // RULE10
          s_nxt.st     = CTL_IDLE;
        end
      end
      CTL_FREQ: begin
        s_nxt.odt = 1'b0; // RULE18
        if (s_r.wait_c == 8'h00) begin
          s_nxt.clk_ok = 1'b1;
        end
        if (!s_r.ctrl[CTRL_FREQ_BIT] && s_r.clk_ok) begin
          s_nxt.clk_ok = 1'b0;
          s_nxt.wait_c = FREQ_STABLE_CYC; // RULE19
          s_nxt.st     = CTL_FSTAB;
        end
      end
      CTL_FSTAB: begin
        s_nxt.odt = 1'b0;
        if (s_r.wait_c == 8'h00 && cke_can) begin
          s_nxt.cke    = 1'b1; // RULE19
          s_nxt.hold   = 2'h0;
          s_nxt.wait_c = XP_CYC;
          s_nxt.st     = CTL_DLLRST;
        end
      end
      CTL_DLLRST: begin
        s_nxt.odt = 1'b0;
        if (s_r.wait_c == 8'h00) begin
          s_nxt.cmd    = CMD_MRL; // RULE20
          s_nxt.ba     = 3'h0;
          s_nxt.addr   = MR_DLL_RESET_VAL;
          s_nxt.wait_c = RELOCK_CYC;
          s_nxt.rd_blk = RELOCK_CYC;
          s_nxt.st     = CTL_RELOCK;
        end
      end
      CTL_RELOCK: begin
        s_nxt.odt = 1'b0; // RULE21
        if (s_r.wait_c == 8'h00) begin
          s_nxt.st = CTL_IDLE;
        end
      end
      default: s_nxt.st = CTL_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{st: CTL_IDLE, cke: 1'b1, odt: 1'b0, cmd: CMD_NOP,
               ba: 3'h0, addr: 13'h0000, banks: 8'h00, guard: 8'h00,
               hold: CKE_MIN_CYC, wait_c: 8'h00, rd_blk: 8'h00,
               ctrl: CTRL_RESET, pend: 1'b0, op: OP_NOP, pba: 3'h0,
               paddr: 13'h0000, err: 1'b0, clk_ok: 1'b0,
               rdata: 32'h00000000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata    = s_r.rdata;
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !mapped;
  assign link.cke  = s_r.cke;
  assign link.odt  = s_r.odt;
  assign link.cs_n = s_r.cmd[3];
  assign link.ras_n = s_r.cmd[2];
  assign link.cas_n = s_r.cmd[1];
  assign link.we_n = s_r.cmd[0];
  assign link.ba   = s_r.ba;
  assign link.addr = s_r.addr;
endmodule

// ==== ddrpw_props.sv ====
// Concurrent checks on the CKE power-state link between both ends.
`timescale 1ns/1ns
module ddrpw_props (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    cke,
  input wire logic                    cs_n,
  input wire logic                    ras_n,
  input wire logic                    cas_n,
  input wire logic                    we_n,
  input ddrpw_pkg::ddrpw_dev_state_t  dev_state,
  input wire logic [7:0]              banks_open,
  input wire logic                    term_on,
  input wire logic                    illegal
);
  import ddrpw_pkg::*;
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [3:0] cmd;
  logic       quiet;
  logic [7:0] xs_r;
  logic [7:0] rd_r;
  assign cmd   = {cs_n, ras_n, cas_n, we_n};
  assign quiet = cs_n | (cmd == CMD_NOP);
  // *************************************************
  // Cycles left after self-refresh exit and cycles since a read
  // *************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs_r <= 8'h00;
      rd_r <= 8'hFF;
    end else begin
      xs_r <= (dev_state == DEV_SR && cke) ? XSRD_CYC - 8'h01 :
              (xs_r != 8'h00) ? xs_r - 8'h01 : 8'h00;
      rd_r <= (cmd == CMD_RD) ? 8'h00 :
              (rd_r != 8'hFF) ? rd_r + 8'h01 : rd_r;
    end
  end
  // *************************************************
  // Assertions
  // *************************************************
  a_hold_low: assert property ($fell(cke) |=> !cke [*2])
    else $error("cke low held under three edges");
  a_hold_high: assert property ($rose(cke) |=> cke [*2])
    else $error("cke high held under three edges");
  a_entry_cmd: assert property ($fell(cke) |-> quiet || cmd == CMD_REF)
    else $error("cke fell with a bad command");
  a_exit_cmd: assert property ($rose(cke) |-> quiet)
    else $error("cke rose with a bad command");
  a_pre_pd: assert property ($fell(cke) && quiet && banks_open == 8'h00 &&
      dev_state == DEV_ACTIVE |=> dev_state == DEV_PD_PRE)
    else $error("precharge power-down not entered");
  a_act_pd: assert property ($fell(cke) && quiet && banks_open != 8'h00 &&
      dev_state == DEV_ACTIVE |=> dev_state == DEV_PD_ACT)
    else $error("active power-down not entered");
  a_sr_enter: assert property ($fell(cke) && cmd == CMD_REF |=>
      dev_state == DEV_SR)
    else $error("self refresh not entered");
  a_sr_idle: assert property ($fell(cke) && cmd == CMD_REF |->
      banks_open == 8'h00)
    else $error("self refresh with a row open");
  a_low_keeps: assert property (dev_state != DEV_ACTIVE && !cke |=>
      dev_state == $past(dev_state))
    else $error("low state left while cke low");
  a_wake_up: assert property (dev_state != DEV_ACTIVE && cke |=>
      dev_state == DEV_ACTIVE)
    else $error("low state not left on cke high");
  a_xsnr_quiet: assert property (xs_r > XSRD_CYC - XSNR_CYC |-> quiet)
    else $error("command too soon after self refresh");
  a_xsrd_read: assert property (xs_r != 8'h00 |-> cmd != CMD_RD)
    else $error("read too soon after self refresh");
  a_read_done: assert property ($fell(cke) |-> rd_r >= RD_DONE_CYC - 8'h01)
    else $error("cke fell during a read burst");
  a_sr_term: assert property (dev_state == DEV_SR [*2] |=> !term_on)
    else $error("termination on in self refresh");
  a_no_illegal: assert property (!illegal)
    else $error("device flagged an illegal combination");
  c_act_pd: cover property (dev_state == DEV_PD_ACT);
  c_pre_pd: cover property (dev_state == DEV_PD_PRE);
  c_sr_exit: cover property (xs_r == 8'h01);
endmodule

// ==== ddrpw_test.sv ====
// Self-checking bench joining both ends of the CKE power-state link.
`timescale 1ns/1ns
module dram_cke_power_state_control_test;
  import ddrpw_pkg::*;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  ddrpw_dev_state_t dev_state;
  logic [7:0]       banks_open;
  logic             fast_exit;
  logic             term_on;
  logic             self_refreshing;
  logic             illegal;
  logic [31:0]      rd;
  logic             err_seen;
  logic [15:0]      lfsr;
  logic [2:0]       bank;
  int               fail_count;
  int               total_checks;
  int               cycles;

  ddrpw_if ddrpw_if_i ();
  ddrpw_ctl ddrpw_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(ddrpw_if_i));
  ddrpw_device ddrpw_device_i (.pclk(pclk), .presetn(presetn),
    .link(ddrpw_if_i), .dev_state(dev_state), .banks_open(banks_open),
    .fast_exit(fast_exit), .term_on(term_on),
    .self_refreshing(self_refreshing), .illegal(illegal));
  ddrpw_props ddrpw_props_i (.pclk(pclk), .presetn(presetn),
    .cke(ddrpw_if_i.cke), .cs_n(ddrpw_if_i.cs_n), .ras_n(ddrpw_if_i.ras_n),
    .cas_n(ddrpw_if_i.cas_n), .we_n(ddrpw_if_i.we_n),
    .dev_state(dev_state), .banks_open(banks_open), .term_on(term_on),
    .illegal(illegal));

  always #5 pclk = ~pclk;

  // A hang is cut short well beyond the thousand or so cycles the run needs.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  // *************************************************
  // Helpers
  // *************************************************
  function automatic logic [15:0] next_rand(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [7:0] bank_bit(logic [2:0] b);
    return 8'h01 << b;
  endfunction

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 400);
    chk(rd & m, v);
  endtask

  task automatic wait_dev(input ddrpw_dev_state_t s);
    int n;
    n = 0;
    while (dev_state !== s && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(dev_state), 32'(s));
  endtask

  task automatic issue(input logic [2:0] op, input logic [2:0] b,
                       input logic [12:0] a);
    apb(1'b1, REG_CMD, 32'(op) | 32'(b) << CMD_BA_LSB |
        32'(a) << CMD_ADDR_LSB);
    wait_stat(32'h1 << STAT_BUSY_BIT, 32'h0);
    repeat (2) @(posedge pclk);
  endtask

  // Power-down entered right after the last command, odt at random.
  task automatic pd_cycle(input ddrpw_dev_state_t s);
    lfsr = next_rand(lfsr);
    apb(1'b1, REG_CTRL, 32'(lfsr[0]) << CTRL_ODT_BIT | 32'h1 << CTRL_PD_BIT);
    wait_dev(s);
    repeat (lfsr[2:1]) @(posedge pclk);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_dev(DEV_ACTIVE);
  endtask

  // *************************************************
  // Main sequence
  // *************************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    lfsr = 16'h0057;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd, 32'h1 << STAT_CKE_BIT);
    apb(1'b1, 12'hFFC, 32'hFFFFFFFF);
    chk(err_seen, 1'b1);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(rd, 32'h0);
    issue(OP_MRL, 3'h0, 13'h1000);
    chk(fast_exit, 1'b0);
    issue(OP_MRL, 3'h0, 13'h0000);
    chk(fast_exit, 1'b1);
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      bank = lfsr[2:0];
      issue(OP_ACT, bank, lfsr[15:3]);
      chk(banks_open, bank_bit(bank));
      pd_cycle(DEV_PD_ACT);
      issue(OP_RD, bank, 13'h0000);
      pd_cycle(DEV_PD_ACT);
      issue(OP_WR, bank, 13'h0400);
      chk(banks_open, 8'h00);
      pd_cycle(DEV_PD_PRE);
    end
    issue(OP_ACT, 3'h1, 13'h0000);
    issue(OP_REF, 3'h0, 13'h0000);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd[STAT_ERR_BIT], 1'b1);
    chk(banks_open, 8'h02);
    apb(1'b1, REG_CTRL, 32'h1 << CTRL_SR_BIT);
    repeat (20) @(posedge pclk);
    chk(32'(dev_state), 32'(DEV_ACTIVE));
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_STAT, 32'h1 << STAT_ERR_BIT);
    wait_stat(32'h1 << STAT_ERR_BIT, 32'h0);
    issue(OP_PRE, 3'h0, 13'h0400);
    chk(banks_open, 8'h00);
    apb(1'b1, REG_CTRL, 32'h1 << CTRL_SR_BIT | 32'h1 << CTRL_ODT_BIT);
    wait_dev(DEV_SR);
    repeat (3) @(posedge pclk);
    chk(term_on, 1'b0);
    chk(self_refreshing, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_dev(DEV_ACTIVE);
    issue(OP_ACT, 3'h2, 13'h0ABC);
    chk(banks_open, 8'h04);
    issue(OP_RD, 3'h2, 13'h0000);
    issue(OP_PRE, 3'h2, 13'h0000);
    apb(1'b1, REG_CTRL, 32'h1 << CTRL_FREQ_BIT);
    wait_stat(32'h1 << STAT_CLK_BIT, 32'h1 << STAT_CLK_BIT);
    chk(32'(dev_state), 32'(DEV_PD_PRE));
    chk(ddrpw_if_i.odt, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_dev(DEV_ACTIVE);
    wait_stat(32'h7, 32'h0);
    chk(fast_exit, 1'b1);
    give_verdict();
  end
endmodule
